// [hdl/scs_serial_control.sv]
// Serial channel control: link-side shift register, chip-select latch and channel outputs
// Function
// R1: Eight-bit shift register feeding eight-bit latch.
// R2: First shifted bit lands on channel seven.
// R3: Sample data on each rising serial clock.
// R4: Chip-select rising edge copies shift register out.
// R5: Chip-select falling edge leaves outputs unchanged.
// R6: Buffer serial clock and chip-select outward.
// R7: Data output carries bits shifted out.
// R8: Chained devices form one long shift register.
// R9: Master rewrites whole chain for any change.
// R10: Master chains at most sixteen at 10MHz.
// R11: Interface enable low ignores the serial link.
// R12: Force-off pin sets all channels together.
// R13: Force-off wins; otherwise latch governs channels. The code sets all channels on instead while interface enable is low.
// R14: Latched one turns channel bias on.
`timescale 1ns/1ps
`default_nettype none

module scs_serial_control
   import scs_pkg::*;
#(
   parameter int CHANNELS = scs_pkg::SCS_CHANNELS
) (
   // System clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   // Serial link, clocked by the master
   input  wire logic                   serialClockIn,
   input  wire scs_pkg::scs_link_in_t  linkIn,
   // Serial link toward the next device
   output var  logic                   serialClockOut,
   output var  scs_pkg::scs_link_out_t linkOut,
   // Static control pins
   input  wire scs_pkg::scs_static_in_t staticIn,
   // Channel bias controls and status
   output var  logic [CHANNELS-1:0]    channelControlOutput,
   output var  logic                   latchUpdate
);

   if (CHANNELS != SCS_CHANNELS) begin
      $error("scs_serial_control: CHANNELS must be 8");
   end

   // Link domain state
   typedef struct packed {
      logic [CHANNELS-1:0] shift;
   } scs_link_state_t;

   // System domain state
   typedef struct packed {
      logic                csPrev;
      logic [CHANNELS-1:0] latch;
      logic [CHANNELS-1:0] channelOut;
      logic                latchUpdate;
   } scs_sys_state_t;

   scs_link_state_t lst;
   scs_link_state_t next_lst;
   scs_sys_state_t  sst;
   scs_sys_state_t  next_sst;

   logic [SCS_SYNC_WIDTH-1:0] pinsRaw;
   logic [SCS_SYNC_WIDTH-1:0] pinsSync;
   logic                      csSyncHigh;
   logic                      enSync;
   logic                      offSync;
   logic                      csRise;

   // Link domain

   // Shift while selected; first bit travels to the top position
   always_comb begin
      next_lst = lst;
      if (!linkIn.chipSelectInN) begin
         next_lst.shift = {lst.shift[CHANNELS-2:0], linkIn.serialDataIn}; // R1 R2 R3 R8
      end
   end

   always_ff @(posedge serialClockIn or negedge rst_n) begin
      if (!rst_n) begin
         lst <= '{shift: SCS_SHIFT_RESET};
      end else begin
         lst <= next_lst;
      end
   end

   // Buffered copies for a chained device; clock and select pass straight through
   assign serialClockOut = serialClockIn; // R6
   assign linkOut        = '{serialDataOut: lst.shift[CHANNELS-1], chipSelectOutN: linkIn.chipSelectInN}; // R6 R7

   // System domain

   always_comb begin
      pinsRaw               = '0;
      pinsRaw[SCS_SYNC_CS]  = linkIn.chipSelectInN;
      pinsRaw[SCS_SYNC_EN]  = staticIn.interfaceEnable;
      pinsRaw[SCS_SYNC_OFF] = staticIn.forceAllChannelsOff;
   end

   // Reset level of one keeps channels off until pins are known
   scs_sync #(
      .WIDTH       (SCS_SYNC_WIDTH),
      .RESET_VALUE (SCS_SYNC_RESET)
   ) u_pin_sync (
      .clk     (clk),
      .rst_n   (rst_n),
      .asyncIn (pinsRaw),
      .syncOut (pinsSync)
   );

   assign csSyncHigh = pinsSync[SCS_SYNC_CS];
   assign enSync     = pinsSync[SCS_SYNC_EN];
   assign offSync    = pinsSync[SCS_SYNC_OFF];
   assign csRise     = csSyncHigh && !sst.csPrev;

   // Shift word is quiet while deselected, so it is read once the select edge is agreed
   always_comb begin
      next_sst             = sst;
      next_sst.csPrev      = csSyncHigh;
      next_sst.latchUpdate = 1'b0;
      if (csRise && enSync) begin // R4 R5 R11
         next_sst.latch       = lst.shift;
         next_sst.latchUpdate = 1'b1;
      end
      if (offSync) begin
         next_sst.channelOut = '0; // R12 R13
      end else if (!enSync) begin
         next_sst.channelOut = '1; // R12
      end else begin
         next_sst.channelOut = sst.latch; // R13 R14
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sst <= '{csPrev: 1'b1, latch: SCS_LATCH_RESET, channelOut: SCS_LATCH_RESET, latchUpdate: 1'b0};
      end else begin
         sst <= next_sst;
      end
   end

   assign channelControlOutput = sst.channelOut;
   assign latchUpdate          = sst.latchUpdate;

   // Checks, link domain

   a_shift_sample: assert property (@(posedge serialClockIn) disable iff (!rst_n) // R3
      !linkIn.chipSelectInN |=> lst.shift[0] == $past(linkIn.serialDataIn))
      else $error("serial data not sampled into shift register");

   a_shift_order: assert property (@(posedge serialClockIn) disable iff (!rst_n) // R2
      !linkIn.chipSelectInN |=> lst.shift[CHANNELS-1:1] == $past(lst.shift[CHANNELS-2:0]))
      else $error("shift register did not move toward the top bit");

   a_shift_hold: assert property (@(posedge serialClockIn) disable iff (!rst_n) // R1
      linkIn.chipSelectInN |=> $stable(lst.shift))
      else $error("shift register moved while deselected");

   a_chain_delay: assert property (@(posedge serialClockIn) disable iff (!rst_n) // R7
      (!linkIn.chipSelectInN) [*8] |=> linkOut.serialDataOut == $past(linkIn.serialDataIn, 8))
      else $error("data out is not data in delayed by eight shifts");

   // Checks, system domain

   sequence s_select_edge;
      csRise ##0 enSync;
   endsequence

   a_latch_capture: assert property (@(posedge clk) disable iff (!rst_n) // R4
      s_select_edge |=> (sst.latch == $past(lst.shift)) && latchUpdate)
      else $error("latch did not take shift word at select rising edge");

   a_latch_steady: assert property (@(posedge clk) disable iff (!rst_n) // R5
      !csRise |=> $stable(sst.latch) && !latchUpdate)
      else $error("latch changed without a select rising edge");

   a_link_ignored: assert property (@(posedge clk) disable iff (!rst_n) // R11
      !enSync |=> $stable(sst.latch))
      else $error("latch changed while the interface is disabled");

   a_force_off: assert property (@(posedge clk) disable iff (!rst_n) // R12
      ($rose(staticIn.forceAllChannelsOff) ##1 staticIn.forceAllChannelsOff [*4])
         |-> ##1 channelControlOutput == '0)
      else $error("force-off pin did not turn every channel off in time");

   a_static_on: assert property (@(posedge clk) disable iff (!rst_n) // R12
      (!offSync && !enSync) |=> channelControlOutput == '1)
      else $error("channels not all on with interface disabled and force-off low");

   a_latch_governs: assert property (@(posedge clk) disable iff (!rst_n) // R13
      (!offSync && enSync) |=> channelControlOutput == $past(sst.latch))
      else $error("channel outputs do not follow the latch");

   a_off_wins: assert property (@(posedge clk) disable iff (!rst_n) // R13
      offSync [*2] |-> channelControlOutput == '0)
      else $error("channel on while force-off is agreed high");

   a_bit_polarity: assert property (@(posedge clk) disable iff (!rst_n) // R14
      (s_select_edge ##1 (!offSync && enSync)) |=> channelControlOutput == $past(lst.shift, 2))
      else $error("latched one did not turn its channel on");

endmodule

`default_nettype wire

// [hdl/scs_sync.sv]
// Three-stage synchroniser whose output moves once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module scs_sync #(
   parameter int               WIDTH       = 1,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Level from another domain
   input  wire logic [WIDTH-1:0] asyncIn,
   // Agreed level
   output var  logic [WIDTH-1:0] syncOut
);

   if (WIDTH < 1) begin
      $error("scs_sync: WIDTH must be at least 1");
   end

   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
      logic [WIDTH-1:0] stage3;
      logic [WIDTH-1:0] agreed;
   } scs_sync_state_t;

   scs_sync_state_t st;
   scs_sync_state_t next_st;

   always_comb begin
      next_st        = st;
      next_st.stage1 = asyncIn;
      next_st.stage2 = st.stage1;
      next_st.stage3 = st.stage2;
      for (int i = 0; i < WIDTH; i++) begin
         if (st.stage2[i] == st.stage3[i]) begin
            next_st.agreed[i] = st.stage3[i];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '{stage1: RESET_VALUE, stage2: RESET_VALUE, stage3: RESET_VALUE, agreed: RESET_VALUE};
      end else begin
         st <= next_st;
      end
   end

   assign syncOut = st.agreed;

   // Only the bits that moved are held against the input; other bits may still be settling
   a_sync_latency: assert property (@(posedge clk) disable iff (!rst_n) // R4
      $changed(syncOut) |-> ((syncOut ^ $past(asyncIn, 3)) & (syncOut ^ $past(syncOut))) == '0)
      else $error("synchronised level does not match input three cycles earlier");

endmodule

`default_nettype wire

// [pkg/scs_pkg.sv]
// Constants and carrier types for the switch channel serial control block
package scs_pkg;

   // Channel count and shift register length of one device
   localparam int SCS_CHANNELS = 8;

   // Value after reset: every channel bias off
   localparam logic [7:0] SCS_LATCH_RESET = 8'h00;
   localparam logic [7:0] SCS_SHIFT_RESET = 8'h00;

   // Static pin synchroniser bit positions and reset levels
   localparam int SCS_SYNC_WIDTH = 3;
   localparam int SCS_SYNC_CS    = 0;
   localparam int SCS_SYNC_EN    = 1;
   localparam int SCS_SYNC_OFF   = 2;
   localparam logic [2:0] SCS_SYNC_RESET = 3'h7;

   // Synchroniser depth and latency from pin to agreed level
   localparam int SCS_SYNC_STAGES  = 3;
   localparam int SCS_SYNC_LATENCY = 3;

   // Serial link inputs that travel with the link clock
   typedef struct packed {
      logic serialDataIn;
      logic chipSelectInN;
   } scs_link_in_t;

   // Serial link outputs toward the next device of a chain
   typedef struct packed {
      logic serialDataOut;
      logic chipSelectOutN;
   } scs_link_out_t;

   // Static control pins
   typedef struct packed {
      logic interfaceEnable;
      logic forceAllChannelsOff;
   } scs_static_in_t;

endpackage

// [verification/scs_master_model.sv]
// Serial master model driving one whole chain of blocks
`timescale 1ns/1ps
`default_nettype none

module scs_master_model (
   // Serial link toward the chain
   output var logic                  serialClockIn,
   output var scs_pkg::scs_link_in_t linkIn
);
   import scs_pkg::*;

   initial begin
      serialClockIn = 1'b0;
      linkIn = '{serialDataIn: 1'b0, chipSelectInN: 1'b1};
   end

   // Two blocks: sixteen bits per frame, then one stray clock edge after deselect
   task automatic frame(input logic [15:0] w);
      #7;
      linkIn = '{serialDataIn: w[15], chipSelectInN: 1'b0};
      for (int i = 15; i >= 0; i--) begin
         #31;
         serialClockIn = 1'b1;
         #62;
         serialClockIn = 1'b0;
         #32;
         if (i > 0) begin
            linkIn.serialDataIn = w[i-1];
         end
      end
      // Released data line must not look like held data
      linkIn = '{serialDataIn: ~w[0], chipSelectInN: 1'b1};
      // One stray edge while deselected, before the latch is taken, must not shift
      #31;
      serialClockIn = 1'b1;
      #62;
      serialClockIn = 1'b0;
   endtask

   task automatic select(input logic level);
      linkIn.chipSelectInN = level;
   endtask
endmodule

`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench: two chained blocks fed by the serial master model
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import scs_pkg::*;
   logic           clk;
   logic           rst_n;
   logic           sclk;
   logic           sclk2;
   scs_link_in_t   link;
   scs_link_in_t   link2;
   scs_link_out_t  out1;
   scs_static_in_t pins;
   logic [7:0]     chan1;
   logic [7:0]     chan2;
   logic           upd1;
   logic           upd2;
   logic [7:0]     exp1[$];
   logic [7:0]     exp2[$];
   int             fails;
   int             comparisons;
   logic [15:0]    word;

   assign link2 = '{serialDataIn: out1.serialDataOut, chipSelectInN: out1.chipSelectOutN};

   scs_master_model i_master (.serialClockIn(sclk), .linkIn(link));
   scs_serial_control i_dut (.clk(clk), .rst_n(rst_n), .serialClockIn(sclk), .linkIn(link),
      .serialClockOut(sclk2), .linkOut(out1), .staticIn(pins),
      .channelControlOutput(chan1), .latchUpdate(upd1));
   scs_serial_control i_dut_far (.clk(clk), .rst_n(rst_n), .serialClockIn(sclk2), .linkIn(link2),
      .serialClockOut(), .linkOut(), .staticIn(pins),
      .channelControlOutput(chan2), .latchUpdate(upd2));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] want);
      comparisons++;
      if (seen !== want) begin
         fails++;
         $display("ERROR %s expected %h seen %h", name, want, seen);
      end
   endtask

   task automatic print_verdict();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Channel outputs settle one clock after each latch pulse
   always @(negedge clk) begin
      if (upd1 === 1'b1) begin
         @(negedge clk);
         check("near channels", chan1, exp1.size() ? exp1.pop_front() : 8'hxx);
      end
   end

   always @(negedge clk) begin
      if (upd2 === 1'b1) begin
         @(negedge clk);
         check("far channels", chan2, exp2.size() ? exp2.pop_front() : 8'hxx);
      end
   end

   // Both levels of the pass-through copies, on every change of clock or select
   always @(sclk or link.chipSelectInN) begin
      #1;
      check("buffered clock, select", {6'h00, sclk2, out1.chipSelectOutN}, {6'h00, sclk, link.chipSelectInN});
   end

   initial begin
      pins = '{interfaceEnable: 1'b1, forceAllChannelsOff: 1'b0};
      rst_n = 1'b0;
      fails = 0;
      comparisons = 0;
      void'($urandom(21234));
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      repeat (8) @(negedge clk);
      for (int k = 0; k < 4; k++) begin
         word = (k == 0) ? 16'h8001 : 16'($urandom);
         exp1.push_back(word[7:0]);
         exp2.push_back(word[15:8]);
         i_master.frame(word);
         repeat (12) @(negedge clk);
      end
      $display("test chained frames done");
      i_master.select(1'b0);
      repeat (12) @(negedge clk);
      check("select fall", chan1, word[7:0]);
      check("far select fall", chan2, word[15:8]);
      exp1.push_back(word[7:0]);
      exp2.push_back(word[15:8]);
      i_master.select(1'b1);
      repeat (12) @(negedge clk);
      $display("test select edges done");
      pins.forceAllChannelsOff = 1'b1;
      repeat (8) @(negedge clk);
      check("forced off", chan1, 8'h00);
      pins.interfaceEnable = 1'b0;
      i_master.frame(16'($urandom));
      repeat (12) @(negedge clk);
      check("forced off, link off", chan1, 8'h00);
      pins.forceAllChannelsOff = 1'b0;
      repeat (8) @(negedge clk);
      check("all on", chan1, 8'hFF);
      pins.interfaceEnable = 1'b1;
      repeat (8) @(negedge clk);
      check("latch kept", chan1, word[7:0]);
      check("pending", 8'(exp1.size() + exp2.size()), 8'h00);
      $display("test static pins done");
      print_verdict();
   end

   initial begin
      #200us;
      fails++;
      print_verdict();
   end
endmodule

`default_nettype wire
